// >>> hw/pmbus_bank_device.sv
// device end: fault limits, reactions, startup timing and summary word
// assumes the host keeps frames of 25 bits and the user side is synchronous
`timescale 1ns/1ps
`include "pmbus_bank_defs.svh"
module pmbus_bank_device #(
	parameter int MS_CYCLES = `MS_CYCLES // ref cycles per millisecond
) (
	input  wire logic        I_REF_CLK,
	input  wire logic        I_RST_B,
	pmbus_link_if.device     link,
	input  wire logic        I_ON_CMD,    // user asks for output on
	input  wire logic        I_VOUT_OV,   // output over-voltage present
	input  wire logic        I_IOUT_OC,   // output over-current present
	input  wire logic        I_OT,        // over-temperature present
	input  wire logic        I_VIN_OV,    // input over-voltage present
	input  wire logic        I_VIN_UV,    // input under-voltage present
	output logic             O_OUTPUT_EN, // output stage enabled
	output logic             O_RAMPING,   // output rising
	output logic [15:0]      O_OC_TRIP,
	output logic [15:0]      O_OC_ALERT,
	output logic [15:0]      O_OT_TRIP,
	output logic [15:0]      O_OT_ALERT,
	output logic [15:0]      O_VIN_TRIP
);
	initial begin
		if (MS_CYCLES < 1 || MS_CYCLES > 65536)
			$error("MS_CYCLES out of range");
	end
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0]               clk_s;  // link clock synchroniser
		logic                     clk_d;  // previous synced clock
		logic [1:0]               frm_s;  // frame synchroniser
		logic                     frm_d;  // previous synced frame
		logic [1:0]               dat_s;  // host data synchroniser
		logic [4:0]               nbits;  // bits taken this frame
		logic [24:0]              sh;     // incoming frame
		logic [15:0]              rd;     // outgoing read word
		logic                     miso;   // device data pin
		logic [2:0][2:0]          retry;  // restart policy, ov/oc/ot
		logic [15:0]              oc_trip;
		logic [15:0]              oc_alert;
		logic [15:0]              ot_trip;
		logic [15:0]              ot_alert;
		logic [15:0]              vin_trip;
		logic [15:0]              ton_wait;
		logic [15:0]              ramp;
		logic                     inv_cmd;  // communication flags
		logic                     inv_data;
		pmbus_bank_pkg::dev_state_e st;
		logic [15:0]              sub;    // cycles within a millisecond
		logic [15:0]              ms;     // milliseconds in this phase
		logic                     latch;  // shut down, no restart
		logic                     out_en;
		logic                     rising;
	} dev_s;
	dev_s s;
	dev_s next_s;
	// range test shared by every limit write
	function automatic logic in_range(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction
	// reaction byte as read back; every caller passes the shutdown code
	function automatic logic [7:0] react_byte(input logic [1:0] code,
		input logic [2:0] rs);
		react_byte = {code, rs, `WAIT_NONE};
	endfunction
	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic        rise;
		logic        fend;
		logic [7:0]  cmd;
		logic [15:0] wd;
		logic [15:0] rv;
		logic [15:0] sw;
		logic [1:0]  code;
		logic        set_cmd;
		logic        set_data;
		logic        clr;
		logic        faulted;
		logic        run_ok;
		logic        tick;
		int          idx;
		rise     = 1'b0;
		fend     = 1'b0;
		cmd      = 8'h00;
		wd       = 16'h0000;
		rv       = 16'h0000;
		sw       = 16'h0000;
		code     = `REACT_SHUTDOWN;
		set_cmd  = 1'b0;
		set_data = 1'b0;
		clr      = 1'b0;
		faulted  = 1'b0;
		run_ok   = 1'b0;
		tick     = 1'b0;
		idx      = 0;
		next_s   = s;
		// pins pass two flops before any logic looks at them
		next_s.clk_s = {s.clk_s[0], link.link_clk};
		next_s.frm_s = {s.frm_s[0], link.frame_n};
		next_s.dat_s = {s.dat_s[0], link.host_data};
		next_s.clk_d = s.clk_s[1];
		next_s.frm_d = s.frm_s[1];
		rise = s.clk_s[1] & ~s.clk_d & ~s.frm_s[1];
		fend = s.frm_s[1] & ~s.frm_d;
		// summary word from live fault states and own state
		sw[`SW_VOUT]    = I_VOUT_OV;
		sw[`SW_IOUT]    = I_IOUT_OC;
		sw[`SW_INPUT]   = I_VIN_OV | I_VIN_UV;
		sw[`SW_PG_N]    = (s.st != pmbus_bank_pkg::DEV_ON);
		sw[`SW_BUSY]    = ~s.frm_d;
		sw[`SW_OFF]     = ~s.out_en;
		sw[`SW_VOUT_OV] = I_VOUT_OV;
		sw[`SW_IOUT_OC] = I_IOUT_OC;
		sw[`SW_VIN_UV]  = I_VIN_UV;
		sw[`SW_TEMP]    = I_OT;
		sw[`SW_CML]     = s.inv_cmd | s.inv_data;
		// shift in one bit per link clock rise
		if (rise) begin
			next_s.sh    = {s.sh[23:0], s.dat_s[1]};
			next_s.nbits = s.nbits + 5'd1;
			next_s.miso  = s.rd[15];
			next_s.rd    = {s.rd[14:0], 1'b0};
			if (next_s.nbits == `CMD_BITS) begin
				// command known: load the read word, first bit goes out now
				unique case (next_s.sh[7:0])
				`CMD_OV_REACT:  rv = {8'h00, react_byte(`REACT_SHUTDOWN,
					s.retry[0])};
				`CMD_OC_REACT:  rv = {8'h00, react_byte(`REACT_SHUTDOWN,
					s.retry[1])};
				`CMD_OT_REACT:  rv = {8'h00, react_byte(`REACT_SHUTDOWN,
					s.retry[2])};
				`CMD_VIN_REACT: rv = {8'h00, `VIN_REACT_BYTE};
				`CMD_OC_TRIP:   rv = s.oc_trip;
				`CMD_OC_ALERT:  rv = s.oc_alert;
				`CMD_OT_TRIP:   rv = s.ot_trip;
				`CMD_OT_ALERT:  rv = s.ot_alert;
				`CMD_VIN_TRIP:  rv = s.vin_trip;
				`CMD_TURN_ON_WAIT: rv = s.ton_wait;
				`CMD_RAMP_TIME: rv = s.ramp;
				`CMD_SUMMARY:   rv = sw;
				default:        rv = 16'h0000;
				endcase
				next_s.miso = rv[15];
				next_s.rd   = {rv[14:0], 1'b0};
			end
		end
		// frame over: act on a complete frame only, drop partial ones
		if (fend) begin
			next_s.nbits = 5'd0;
			next_s.miso  = 1'b0;
			cmd = s.sh[23:16];
			wd  = s.sh[15:0];
			if (s.nbits == `FRAME_BITS && s.sh[24]) begin
				// read: unknown commands are flagged, data reads as zero
				unique case (cmd)
				`CMD_OV_REACT, `CMD_OC_REACT, `CMD_OT_REACT,
				`CMD_VIN_REACT, `CMD_OC_TRIP, `CMD_OC_ALERT,
				`CMD_OT_TRIP, `CMD_OT_ALERT, `CMD_VIN_TRIP,
				`CMD_TURN_ON_WAIT, `CMD_RAMP_TIME,
				`CMD_SUMMARY: set_cmd = 1'b0;
				default:      set_cmd = 1'b1;
				endcase
			end else if (s.nbits == `FRAME_BITS) begin
				unique case (cmd)
				`CMD_OV_REACT, `CMD_OC_REACT, `CMD_OT_REACT: begin
					idx = (cmd == `CMD_OV_REACT) ? 0 :
						(cmd == `CMD_OC_REACT) ? 1 : 2;
					// fixed fields must match, retry never or always
					if (wd[15:8] == 8'h00 &&
						wd[`REACT_CODE_HI:`REACT_CODE_LO] == code &&
						wd[`WAIT_HI:`WAIT_LO] == `WAIT_NONE &&
						(wd[`RESTART_HI:`RESTART_LO] == `RESTART_NEVER ||
						wd[`RESTART_HI:`RESTART_LO] == `RESTART_ALWAYS))
						next_s.retry[idx] =
							wd[`RESTART_HI:`RESTART_LO];
					else
						set_data = 1'b1;
				end
				`CMD_OC_TRIP: begin
					if (in_range(wd, `OC_TRIP_MIN, `OC_TRIP_MAX) &&
						wd > s.oc_alert) next_s.oc_trip = wd;
					else set_data = 1'b1;
				end
				`CMD_OC_ALERT: begin
					if (in_range(wd, `OC_ALERT_MIN, `OC_ALERT_MAX) &&
						wd < s.oc_trip) next_s.oc_alert = wd;
					else set_data = 1'b1;
				end
				`CMD_OT_TRIP: begin
					if (in_range(wd, `OT_TRIP_MIN, `OT_TRIP_MAX) &&
						wd > s.ot_alert) next_s.ot_trip = wd;
					else set_data = 1'b1;
				end
				`CMD_OT_ALERT: begin
					if (in_range(wd, `OT_ALERT_MIN, `OT_ALERT_MAX) &&
						wd < s.ot_trip) next_s.ot_alert = wd;
					else set_data = 1'b1;
				end
				`CMD_VIN_TRIP: begin
					if (in_range(wd, `VIN_TRIP_MIN, `VIN_TRIP_MAX))
						next_s.vin_trip = wd;
					else set_data = 1'b1;
				end
				`CMD_TURN_ON_WAIT: begin
					if (in_range(wd, `WAIT_MS_MIN, `WAIT_MS_MAX))
						next_s.ton_wait = wd;
					else set_data = 1'b1;
				end
				`CMD_RAMP_TIME: begin
					if (in_range(wd, `RAMP_MS_MIN, `RAMP_MS_MAX))
						next_s.ramp = wd;
					else set_data = 1'b1;
				end
				// the read-only byte and the summary word refuse every write
				`CMD_VIN_REACT, `CMD_SUMMARY: set_data = 1'b1;
				`CMD_CLEAR_FAULTS: clr = 1'b1;
				default: set_cmd = 1'b1;
				endcase
			end
		end
		// a new error in the clearing cycle survives the clear
		next_s.inv_cmd  = (s.inv_cmd & ~clr) | set_cmd;
		next_s.inv_data = (s.inv_data & ~clr) | set_data;
		// no-restart policy latches off until the user commands off
		faulted = (I_VOUT_OV & (s.retry[0] == `RESTART_NEVER)) |
			(I_IOUT_OC & (s.retry[1] == `RESTART_NEVER)) |
			(I_OT & (s.retry[2] == `RESTART_NEVER));
		next_s.latch = (s.latch & I_ON_CMD) | faulted;
		// any fault but input under-voltage drops the output at the next clock edge, no wait
		run_ok = I_ON_CMD & ~s.latch & ~faulted & ~I_VOUT_OV & ~I_IOUT_OC &
			~I_OT & ~I_VIN_OV;
		tick = (s.sub == 16'(MS_CYCLES - 1));
		next_s.sub = tick ? 16'h0000 : s.sub + 16'h0001;
		next_s.ms  = tick ? s.ms + 16'h0001 : s.ms;
		unique case (s.st)
		pmbus_bank_pkg::DEV_OFF: begin
			next_s.sub = 16'h0000;
			next_s.ms  = 16'h0000;
			if (run_ok) next_s.st = pmbus_bank_pkg::DEV_WAIT;
		end
		pmbus_bank_pkg::DEV_WAIT: begin
			if (s.ms >= s.ton_wait) begin
				next_s.st  = pmbus_bank_pkg::DEV_RAMP;
				next_s.sub = 16'h0000;
				next_s.ms  = 16'h0000;
			end
		end
		pmbus_bank_pkg::DEV_RAMP: begin
			if (s.ms >= s.ramp) next_s.st = pmbus_bank_pkg::DEV_ON;
		end
		pmbus_bank_pkg::DEV_ON: next_s.st = pmbus_bank_pkg::DEV_ON;
		endcase
		// input over-voltage only holds off; startup resumes after it
		if (!run_ok) next_s.st = pmbus_bank_pkg::DEV_OFF;
		next_s.out_en = (next_s.st == pmbus_bank_pkg::DEV_RAMP) ||
			(next_s.st == pmbus_bank_pkg::DEV_ON);
		next_s.rising = (next_s.st == pmbus_bank_pkg::DEV_RAMP);
	end
	// ----------------------------------------------------------------
	// state register; reactions reset to always restart
	// ----------------------------------------------------------------
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			s          <= '0;
			s.clk_s    <= 2'h0;
			s.frm_s    <= 2'h3;
			s.frm_d    <= 1'b1;
			s.dat_s    <= 2'h0;
			s.retry    <= {3{`RESTART_ALWAYS}};
			s.oc_trip  <= `OC_TRIP_RST;
			s.oc_alert <= `OC_ALERT_RST;
			s.ot_trip  <= `OT_TRIP_RST;
			s.ot_alert <= `OT_ALERT_RST;
			s.vin_trip <= `VIN_TRIP_RST;
			s.ton_wait <= `WAIT_MS_RST;
			s.ramp     <= `RAMP_MS_RST;
			s.st       <= pmbus_bank_pkg::DEV_OFF;
		end else begin
			s <= next_s;
		end
	end
	assign link.dev_data = s.miso;
	assign O_OUTPUT_EN   = s.out_en;
	assign O_RAMPING     = s.rising;
	assign O_OC_TRIP     = s.oc_trip;
	assign O_OC_ALERT    = s.oc_alert;
	assign O_OT_TRIP     = s.ot_trip;
	assign O_OT_ALERT    = s.ot_alert;
	assign O_VIN_TRIP    = s.vin_trip;
endmodule

// >>> hw/pmbus_bank_defs.svh
// command codes, field layouts, reset values, ranges and timing counts
// assumes it is included by bare name wherever these macros are used
`ifndef PMBUS_BANK_DEFS_SVH
`define PMBUS_BANK_DEFS_SVH
// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_OV_REACT     8'h41
`define CMD_OC_TRIP      8'h46
`define CMD_OC_REACT     8'h47
`define CMD_OC_ALERT     8'h4a
`define CMD_OT_TRIP      8'h4f
`define CMD_OT_REACT     8'h50
`define CMD_OT_ALERT     8'h51
`define CMD_VIN_TRIP     8'h55
`define CMD_VIN_REACT    8'h56
`define CMD_GOOD_RISE    8'h5e
`define CMD_GOOD_FALL    8'h5f
`define CMD_TURN_ON_WAIT 8'h60
`define CMD_RAMP_TIME    8'h61
`define CMD_SUMMARY      8'h79
// ----------------------------------------------------------------
// reaction byte layout and fixed fields
// ----------------------------------------------------------------
`define REACT_CODE_HI  7
`define REACT_CODE_LO  6
`define RESTART_HI     5
`define RESTART_LO     3
`define WAIT_HI        2
`define WAIT_LO        0
`define REACT_SHUTDOWN 2'h2
`define REACT_HOLD_OFF 2'h3
`define RESTART_NEVER  3'h0
`define RESTART_ALWAYS 3'h7
`define WAIT_NONE      3'h0
`define VIN_REACT_BYTE 8'hc0
// ----------------------------------------------------------------
// limit ranges (plain integer units) and reset values
// ----------------------------------------------------------------
`define OC_TRIP_MIN  16'h0022
`define OC_TRIP_MAX  16'h0096
`define OC_ALERT_MIN 16'h0019
`define OC_ALERT_MAX 16'h0096
`define OT_TRIP_MIN  16'h0019
`define OT_TRIP_MAX  16'h008c
`define OT_ALERT_MIN 16'h0019
`define OT_ALERT_MAX 16'h007d
`define VIN_TRIP_MIN 16'h0030
`define VIN_TRIP_MAX 16'h005a
`define WAIT_MS_MIN  16'h0000
`define WAIT_MS_MAX  16'h01f4
`define RAMP_MS_MIN  16'h000c
`define RAMP_MS_MAX  16'h01f4
`define OC_TRIP_RST  16'h0064
`define OC_ALERT_RST 16'h005a
`define OT_TRIP_RST  16'h007d
`define OT_ALERT_RST 16'h006e
`define VIN_TRIP_RST 16'h0046
`define WAIT_MS_RST  16'h0000
`define RAMP_MS_RST  16'h000c
// ----------------------------------------------------------------
// summary word bit positions
// ----------------------------------------------------------------
`define SW_VOUT    15
`define SW_IOUT    14
`define SW_INPUT   13
`define SW_PG_N    11
`define SW_BUSY    7
`define SW_OFF     6
`define SW_VOUT_OV 5
`define SW_IOUT_OC 4
`define SW_VIN_UV  3
`define SW_TEMP    2
`define SW_CML     1
// ----------------------------------------------------------------
// frame and timing
// ----------------------------------------------------------------
`define FRAME_BITS    5'd25
`define CMD_BITS      5'd9
`define REF_PERIOD_NS 20
`define LINK_PERIOD_NS 160
`define LINK_HALF     (`LINK_PERIOD_NS / (2 * `REF_PERIOD_NS))
`define REF_MHZ       50
`define MS_CYCLES     (`REF_MHZ * 1000)
`endif

// >>> hw/pmbus_bank_pkg.sv
// state types shared by both ends of the limit and reaction link
// assumes the macro header is included by the files that use these types
package pmbus_bank_pkg;
	// device startup sequencer, one-hot
	typedef enum logic [3:0] {
		DEV_OFF  = 4'h1,
		DEV_WAIT = 4'h2,
		DEV_RAMP = 4'h4,
		DEV_ON   = 4'h8
	} dev_state_e;
	// host frame engine, one-hot
	typedef enum logic [2:0] {
		HOST_IDLE  = 3'h1,
		HOST_SHIFT = 3'h2,
		HOST_END   = 3'h4
	} host_state_e;
endpackage

// >>> hw/pmbus_link_if.sv
// serial link between the command host and the device register bank
// assumes the bench ties one host end and one device end to one instance
`timescale 1ns/1ps
interface pmbus_link_if;
	logic link_clk;  // bus clock, made by the host
	logic frame_n;   // frame window, active low
	logic host_data; // host to device, msb first
	logic dev_data;  // device to host, read data
	modport host (
		output link_clk,
		output frame_n,
		output host_data,
		input  dev_data
	);
	modport device (
		input  link_clk,
		input  frame_n,
		input  host_data,
		output dev_data
	);
endinterface

// >>> hw/pmbus_bank_host.sv
// host end: turns one user request into one 25-bit frame on the link
// assumes the device end shares no clock and answers within half a period
`timescale 1ns/1ps
`include "pmbus_bank_defs.svh"
module pmbus_bank_host #(
	parameter int HALF = `LINK_HALF // ref cycles per link clock half
) (
	input  wire logic        I_REF_CLK,
	input  wire logic        I_RST_B,
	pmbus_link_if.host       link,
	input  wire logic        I_START, // one-cycle request
	input  wire logic        I_READ,  // 1 read, 0 write
	input  wire logic [7:0]  I_CMD,
	input  wire logic [15:0] I_WDATA,
	output logic             O_BUSY,
	output logic             O_DONE,  // one-cycle pulse
	output logic [15:0]      O_RDATA
);
	// the device needs four cycles to sync, detect and answer
	initial begin
		if (HALF < 4 || HALF > 256) $error("HALF out of range");
	end
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		pmbus_bank_pkg::host_state_e st;
		logic [7:0]  div;    // cycles in this half period
		logic [4:0]  cnt;    // rises made
		logic [24:0] sh;     // outgoing frame
		logic [15:0] rdata;  // last 16 sampled bits
		logic [1:0]  miso_s; // device data synchroniser
		logic        sclk;
		logic        frame_n;
		logic        mosi;
		logic        busy;
		logic        done;
	} host_s;
	host_s s;
	host_s next_s;
	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic half_up;
		half_up       = (s.div == 8'(HALF - 1));
		next_s        = s;
		next_s.miso_s = {s.miso_s[0], link.dev_data};
		next_s.done   = 1'b0;
		next_s.div    = half_up ? 8'h00 : s.div + 8'h01;
		unique case (s.st)
		pmbus_bank_pkg::HOST_IDLE: begin
			next_s.div = 8'h00;
			if (I_START) begin
				next_s.sh      = {I_READ, I_CMD, I_WDATA};
				next_s.mosi    = I_READ;
				next_s.frame_n = 1'b0;
				next_s.cnt     = 5'd0;
				next_s.busy    = 1'b1;
				next_s.st      = pmbus_bank_pkg::HOST_SHIFT;
			end
		end
		pmbus_bank_pkg::HOST_SHIFT: begin
			if (half_up && !s.sclk) begin
				// rise: device data has settled since the last fall
				next_s.sclk  = 1'b1;
				next_s.rdata = {s.rdata[14:0], s.miso_s[1]};
				next_s.cnt   = s.cnt + 5'd1;
			end else if (half_up) begin
				// fall: next bit out, or close the frame
				next_s.sclk = 1'b0;
				if (s.cnt == `FRAME_BITS) begin
					next_s.frame_n = 1'b1;
					next_s.mosi    = 1'b0;
					next_s.st      = pmbus_bank_pkg::HOST_END;
				end else begin
					next_s.sh   = {s.sh[23:0], 1'b0};
					next_s.mosi = s.sh[23];
				end
			end
		end
		pmbus_bank_pkg::HOST_END: begin
			// frame stays high a half period so the device sees the end
			if (half_up) begin
				next_s.busy = 1'b0;
				next_s.done = 1'b1;
				next_s.st   = pmbus_bank_pkg::HOST_IDLE;
			end
		end
		endcase
	end
	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			s         <= '0;
			s.st      <= pmbus_bank_pkg::HOST_IDLE;
			s.frame_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end
	assign link.link_clk  = s.sclk;
	assign link.frame_n   = s.frame_n;
	assign link.host_data = s.mosi;
	assign O_BUSY         = s.busy;
	assign O_DONE         = s.done;
	assign O_RDATA        = s.rdata;
endmodule

// >>> dv/pmbus_link_assertions.sv
// wire checks on the link between the host end and the device end
// assumes a host half period of 4 reference cycles and whole frames
`timescale 1ns/1ps
module pmbus_link_assertions (
	input wire logic I_REF_CLK,
	input wire logic I_RST_B,
	input wire logic link_clk,
	input wire logic frame_n,
	input wire logic host_data,
	input wire logic dev_data
);
	logic       lc_d;  // link clock one cycle back
	logic [7:0] cyc;   // reference cycles inside a frame
	logic [4:0] rises; // link clock rises inside a frame
	// ------------------------------------------------------------
	// frame counters, cleared whenever the frame window is shut
	// ------------------------------------------------------------
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			lc_d  <= 1'b0;
			cyc   <= 8'h00;
			rises <= 5'h00;
		end else begin
			lc_d  <= link_clk;
			cyc   <= frame_n ? 8'h00 : cyc + 8'h01;
			rises <= frame_n ? 5'h00 : rises + 5'(link_clk & ~lc_d);
		end
	end
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RST_B);
	chk_clk_idle_low: assert property (frame_n |-> !link_clk)
		else $error("link clock high outside a frame");
	chk_data_on_fall: assert property ((!frame_n && !$fell(frame_n) &&
		!$fell(link_clk)) |-> $stable(host_data))
		else $error("host data moved off a falling edge");
	chk_high_half: assert property ($rose(link_clk) |->
		link_clk[*4] ##1 !link_clk)
		else $error("link clock high phase wrong");
	chk_low_half: assert property (($fell(link_clk) && !frame_n) |->
		!link_clk[*4] ##1 link_clk)
		else $error("link clock low phase wrong");
	chk_first_rise: assert property ($fell(frame_n) |->
		!link_clk[*4] ##1 link_clk)
		else $error("first rise not four cycles into frame");
	chk_bit_count: assert property ($rose(frame_n) |-> rises == 5'd25)
		else $error("frame did not carry 25 bits");
	chk_frame_len: assert property ($rose(frame_n) |-> cyc == 8'd200)
		else $error("frame window length wrong");
	chk_dev_steady: assert property ($rose(link_clk) |->
		$stable(dev_data))
		else $error("device data moved at a sampling rise");
	chk_dev_idle: assert property (frame_n[*8] |-> !dev_data)
		else $error("device data not released between frames");
	cover property ($rose(frame_n));
	cover property ($rose(dev_data));
	cover property (!frame_n && host_data);
endmodule

// >>> dv/pmbus_fault_limit_response_bank_tb_top.sv
// bench: host end and device end joined back to back over the link
// assumes one millisecond is shortened to 10 reference cycles
`timescale 1ns/1ps
module pmbus_fault_limit_response_bank_tb_top;
	logic        clk;   // reference clock, 50 MHz
	logic        rst_b; // reset, active low
	logic        st;    // host request pulse
	logic        rw;    // 1 read, 0 write
	logic [7:0]  cm;    // command code
	logic [15:0] wd;    // write word
	logic [15:0] rdat;  // read word, valid after done
	logic        busy;  // host frame in progress
	logic        done;  // host frame finished
	logic        on;    // user wants output on
	logic        en;    // output stage enabled
	logic        ramp;  // output rising
	logic [4:0]  flt;   // vout ov, oc, ot, vin ov, vin uv
	logic [15:0] oct, oca, ott, ota, vit; // stored limits
	int          miscompares;
	int          num_checks;
	pmbus_link_if link_if ();
	pmbus_bank_host #(.HALF(4)) pmbus_bank_host_inst (.I_REF_CLK(clk),
		.I_RST_B(rst_b), .link(link_if.host), .I_START(st), .I_READ(rw),
		.I_CMD(cm), .I_WDATA(wd), .O_BUSY(busy), .O_DONE(done),
		.O_RDATA(rdat));
	pmbus_bank_device #(.MS_CYCLES(10)) pmbus_bank_device_inst (
		.I_REF_CLK(clk), .I_RST_B(rst_b), .link(link_if.device),
		.I_ON_CMD(on), .I_VOUT_OV(flt[0]), .I_IOUT_OC(flt[1]),
		.I_OT(flt[2]), .I_VIN_OV(flt[3]), .I_VIN_UV(flt[4]),
		.O_OUTPUT_EN(en), .O_RAMPING(ramp), .O_OC_TRIP(oct),
		.O_OC_ALERT(oca), .O_OT_TRIP(ott), .O_OT_ALERT(ota),
		.O_VIN_TRIP(vit));
	pmbus_link_assertions pmbus_link_assertions_inst (.I_REF_CLK(clk),
		.I_RST_B(rst_b), .link_clk(link_if.link_clk),
		.frame_n(link_if.frame_n), .host_data(link_if.host_data),
		.dev_data(link_if.dev_data));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ------------------------------------------------------------
	// shared tasks; inputs move 1 ns after a rising edge
	// ------------------------------------------------------------
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic hang;
		miscompares++;
		give_verdict();
	endtask
	task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cmp1(input logic g, input logic e);
		cmp16({15'h0000, g}, {15'h0000, e});
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// one whole frame; the extra cycle keeps the next start legal
	task automatic xfer(input logic r, input logic [7:0] c,
		input logic [15:0] w);
		st = 1'b1;
		rw = r;
		cm = c;
		wd = w;
		tick(1);
		st = 1'b0;
		for (int n = 0; done !== 1'b1; n++) begin
			if (n == 400) hang();
			tick(1);
		end
		tick(1);
	endtask
	task automatic rc(input logic [7:0] c, input logic [15:0] m, e);
		xfer(1'b1, c, 16'h0000);
		cmp16(rdat & m, e);
	endtask
	// bounded wait on the output enable (s=0) or ramp flag (s=1)
	task automatic wt(input logic s, input logic v, output int n);
		for (n = 0; (s ? ramp : en) !== v; n++) begin
			if (n == 400) hang();
			tick(1);
		end
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		logic [23:0] t [11] = '{24'h4100b8, 24'h4700b8, 24'h5000b8,
			24'h5600c0, 24'h460064, 24'h4a005a, 24'h4f007d, 24'h51006e,
			24'h550046, 24'h600000, 24'h61000c};
		foreach (t[i]) rc(t[i][23:16], 16'hffff, t[i][15:0]);
		rc(8'h79, 16'hff7f, 16'h0840);
	endtask
	// each entry: command, word written, word expected back
	task automatic t_write;
		logic [39:0] t [35] = '{40'h4100800080, 40'h4100bc0080,
			40'h4100f80080, 40'h4100900080, 40'h4100b800b8,
			40'h4700800080, 40'h4700f80080, 40'h4700b800b8,
			40'h5000f800b8, 40'h5000800080, 40'h5000b800b8,
			40'h56008000c0, 40'h4600960096, 40'h4600970096,
			40'h4600590096, 40'h4a0096005a, 40'h4a00190019,
			40'h4a00180019, 40'h4600220022, 40'h4600210022,
			40'h4f008c008c, 40'h4f008d008c, 40'h51007d007d,
			40'h51007e007d, 40'h4f007d008c, 40'h5500300030,
			40'h55002f0030, 40'h55005a005a, 40'h55005b005a,
			40'h6001f401f4, 40'h6001f501f4, 40'h61000b000c,
			40'h6101f401f4, 40'h6000010001, 40'h61000c000c};
		foreach (t[i]) begin
			xfer(1'b0, t[i][39:32], t[i][31:16]);
			rc(t[i][39:32], 16'hffff, t[i][15:0]);
		end
		rc(8'h79, 16'h0002, 16'h0002);
		xfer(1'b0, 8'h03, 16'h0000);
		rc(8'h79, 16'h0002, 16'h0000);
		xfer(1'b1, 8'h5e, 16'h0000);
		rc(8'h79, 16'h0002, 16'h0002);
		xfer(1'b0, 8'h03, 16'h0000);
		cmp16(oct, 16'h0022);
		cmp16(oca, 16'h0019);
		cmp16(ott, 16'h008c);
		cmp16(ota, 16'h007d);
		cmp16(vit, 16'h005a);
	endtask
	// wait of 1 ms and ramp of 12 ms, 10 cycles per millisecond
	task automatic t_start;
		int n;
		int m;
		on = 1'b1;
		wt(1'b1, 1'b1, n);
		cmp1(en, 1'b1);
		wt(1'b1, 1'b0, m);
		cmp1(n >= 10 && n <= 13, 1'b1);
		cmp1(m >= 120 && m <= 123, 1'b1);
		cmp1(en, 1'b1);
		rc(8'h79, 16'hff7f, 16'h0000);
	endtask
	// summary bits expected per fault: vout ov, oc, ot, vin ov, vin uv
	task automatic t_fault;
		int n;
		logic [15:0] sm [5] = '{16'h8020, 16'h4010, 16'h0004,
			16'h2000, 16'h2008};
		for (int i = 0; i < 5; i++) begin
			flt[i] = 1'b1;
			tick(2);
			// under-voltage is only reported, the output keeps running
			cmp1(en, i == 4);
			if (i == 0) rc(8'h79, 16'hff7f, 16'h8860);
			else rc(8'h79, 16'he03c, sm[i]);
			flt[i] = 1'b0;
			if (i < 4) wt(1'b0, 1'b1, n);
		end
		xfer(1'b0, 8'h41, 16'h0080);
		flt[0] = 1'b1;
		tick(2);
		flt[0] = 1'b0;
		tick(50);
		cmp1(en, 1'b0);
		on = 1'b0;
		tick(2);
		on = 1'b1;
		wt(1'b0, 1'b1, n);
	endtask
	initial begin
		rst_b = 1'b0;
		{st, rw, cm, wd, on, flt} = '0;
		miscompares = 0;
		num_checks = 0;
		tick(4);
		rst_b = 1'b1;
		tick(3);
		t_reset();
		t_write();
		t_start();
		t_fault();
		give_verdict();
	end
endmodule
